/* rtl/sfc_synth_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - Host writes only the target mode; sequencer walks every step to reach it.
// - VCO calibration runs on every synthesizer frequency change and every power up.
// - VCO bias settle interval programmable 0 to 70 us, default 50 us.
// - Calibration lasts 50 us and can be bypassed for faster turnaround.
// - Synth settle interval programmable 0 to 310 us, default 100 us.
// - Bias settle, calibration and synth settle together finish within 200 us.
// - Third-order modulator at 10 MHz, accumulators wrap at 64000.
// - Divide ratio integer is band integer plus 24; fraction over 64000.
// - Band integer above 23 is stored as 23.
// - High band uses output directly; low band divides output by two.
// - Fraction combines carrier fraction, offset trim and deviation; FSK follows data.
// - Receive lowers the synthesizer by 937.5 kHz for the IF.
// - Hop step counts in 10 kHz units, up to 2.55 MHz.
// - Carrier rises by channel number times step; one write changes channel.
// - Channel or step change in TX/RX retunes via tune; packet transmit defers it.
module sfc_synth_ctrl #(
	parameter int US_CYC = sfc_pkg::US_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_nsel_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic tx_data,
	input wire logic pkt_active,
	output logic pll_en,
	output logic vco_bias_on,
	output logic vco_cal_on,
	output logic pll_locked,
	output logic pa_en,
	output logic rx_en,
	output logic hb_select,
	output logic lo_div2_en,
	output logic [7:0] div_ratio
);
	localparam int CAL_CYCLES = int'(sfc_pkg::CAL_US) * US_CYC;
	localparam int TOTAL_CYCLES = int'(sfc_pkg::TOTAL_MAX_US) * US_CYC;

	logic rst_ff1_reg;
	logic rst_sync_n_reg;
	sfc_pkg::sfc_reg_wr_t wr;
	logic wr_stb;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] mode_reg;
	logic [7:0] dev_reg;
	logic [7:0] off_lo_reg;
	logic [7:0] off_hi_reg;
	logic [7:0] band_reg;
	logic [7:0] fc_hi_reg;
	logic [7:0] fc_lo_reg;
	logic [7:0] chan_reg;
	logic [7:0] step_reg;
	logic [7:0] seq_cfg_reg;
	logic [7:0] bias_reg;
	logic [7:0] settle_reg;
	logic hb;
	logic vcocal;
	logic pll_req;
	logic target_rx;
	logic target_tx;
	logic [24:0] base_w;
	logic [15:0] hop_prod;
	logic [24:0] hop_w;
	logic [24:0] if_w;
	logic [24:0] offs_w;
	logic [24:0] dev_w;
	logic [24:0] word_nom;
	logic [24:0] word_want;
	logic [24:0] inst_word;
	logic [24:0] applied_word_reg;
	logic applied_hb_reg;
	logic need_retune;
	logic hold_pkt;
	logic [8:0] bias_us;
	logic [8:0] settle_raw;
	logic [8:0] budget_us;
	logic [8:0] settle_us;
	sfc_pkg::sfc_seq_t state_reg;
	sfc_pkg::sfc_seq_t state_next;
	logic tmr_load;
	logic [8:0] tmr_us;
	logic tmr_done;
	logic latch;
	sfc_pkg::sfc_synth_t synth_reg;
	logic [16:0] tmr_cnt_reg;
	logic [16:0] phase_cnt_reg;
	logic [16:0] seq_cnt_reg;

	// Reset is asserted at once and released through two flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_ff1_reg <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_ff1_reg <= 1'b1;
			rst_sync_n_reg <= rst_ff1_reg;
		end
	end

	sfc_spi_port u_spi (
		.mclk(mclk),
		.rst_n(rst_sync_n_reg),
		.spi_sck(spi_sck),
		.spi_nsel_n(spi_nsel_n),
		.spi_sdi(spi_sdi),
		.rd_data(rd_data),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe),
		.wr_stb(wr_stb),
		.wr(wr),
		.rd_addr(rd_addr)
	);

	// Register writes; band integer is clamped on the way in
	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			mode_reg <= sfc_pkg::RST_ZERO;
			dev_reg <= sfc_pkg::RST_DEVIATION;
			off_lo_reg <= sfc_pkg::RST_ZERO;
			off_hi_reg <= sfc_pkg::RST_ZERO;
			band_reg <= sfc_pkg::RST_BAND;
			fc_hi_reg <= sfc_pkg::RST_FRAC_HI;
			fc_lo_reg <= sfc_pkg::RST_FRAC_LO;
			chan_reg <= sfc_pkg::RST_ZERO;
			step_reg <= sfc_pkg::RST_ZERO;
			seq_cfg_reg <= sfc_pkg::RST_SEQ_CFG;
			bias_reg <= sfc_pkg::RST_BIAS_TIME;
			settle_reg <= sfc_pkg::RST_SETTLE_TIME;
		end else if (wr_stb) begin
			case (wr.addr)
				sfc_pkg::ADDR_OP_MODE: mode_reg <= wr.data;
				sfc_pkg::ADDR_DEVIATION: dev_reg <= wr.data;
				sfc_pkg::ADDR_OFFSET_LO: off_lo_reg <= wr.data;
				sfc_pkg::ADDR_OFFSET_HI: off_hi_reg <= {6'h00, wr.data[1:0]};
				sfc_pkg::ADDR_BAND: begin
					band_reg <= (wr.data[4:0] > sfc_pkg::FB_MAX) ? {wr.data[7:5], sfc_pkg::FB_MAX} : wr.data;
				end
				sfc_pkg::ADDR_FRAC_HI: fc_hi_reg <= wr.data;
				sfc_pkg::ADDR_FRAC_LO: fc_lo_reg <= wr.data;
				sfc_pkg::ADDR_CHANNEL: chan_reg <= wr.data;
				sfc_pkg::ADDR_STEP: step_reg <= wr.data;
				sfc_pkg::ADDR_SEQ_CFG: seq_cfg_reg <= {7'h00, wr.data[sfc_pkg::CFG_VCOCAL]};
				sfc_pkg::ADDR_BIAS_TIME: bias_reg <= wr.data;
				sfc_pkg::ADDR_SETTLE_TIME: settle_reg <= wr.data;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (rd_addr)
			sfc_pkg::ADDR_DEV_STATUS: rd_data = {6'h00, pa_en, rx_en};
			sfc_pkg::ADDR_OP_MODE: rd_data = mode_reg;
			sfc_pkg::ADDR_DEVIATION: rd_data = dev_reg;
			sfc_pkg::ADDR_OFFSET_LO: rd_data = off_lo_reg;
			sfc_pkg::ADDR_OFFSET_HI: rd_data = off_hi_reg;
			sfc_pkg::ADDR_BAND: rd_data = band_reg;
			sfc_pkg::ADDR_FRAC_HI: rd_data = fc_hi_reg;
			sfc_pkg::ADDR_FRAC_LO: rd_data = fc_lo_reg;
			sfc_pkg::ADDR_CHANNEL: rd_data = chan_reg;
			sfc_pkg::ADDR_STEP: rd_data = step_reg;
			sfc_pkg::ADDR_SEQ_CFG: rd_data = {pll_locked, seq_cfg_reg[6:0]};
			sfc_pkg::ADDR_BIAS_TIME: rd_data = bias_reg;
			sfc_pkg::ADDR_SETTLE_TIME: rd_data = settle_reg;
			default: rd_data = 8'h00;
		endcase
	end

	assign hb = band_reg[sfc_pkg::BAND_HB];
	assign vcocal = seq_cfg_reg[sfc_pkg::CFG_VCOCAL];
	assign target_tx = mode_reg[sfc_pkg::OPM_TXON];
	assign target_rx = mode_reg[sfc_pkg::OPM_RXON] & ~target_tx;
	assign pll_req = mode_reg[sfc_pkg::OPM_PLLON] | target_rx | target_tx;

	// Desired synthesizer word in fraction steps: N*64000 + fraction + trims
	always_comb begin
		base_w = {18'h00000, {2'h0, band_reg[4:0]} + sfc_pkg::N_OFFSET} * sfc_pkg::FRAC_MOD;
		hop_prod = chan_reg * step_reg;
		hop_w = ({9'h000, hop_prod} * sfc_pkg::HOP_LSB) >> hb;
		if_w = sfc_pkg::IF_LSB >> hb;
		offs_w = {{15{off_hi_reg[1]}}, off_hi_reg[1:0], off_lo_reg};
		word_nom = base_w + {9'h000, fc_hi_reg, fc_lo_reg} + offs_w + hop_w;
		word_want = target_rx ? word_nom - if_w : word_nom;
		dev_w = ({17'h00000, dev_reg} * sfc_pkg::DEV_LSB) >> hb;
	end

	// Any change of word or band, IF shift included, retunes; a packet in flight keeps its frequency
	assign need_retune = {applied_hb_reg, applied_word_reg} != {hb, word_want};
	assign hold_pkt = target_tx & pkt_active;

	// Interval clamps; settle is shortened so the whole turn-on fits its budget
	always_comb begin
		bias_us = ({1'b0, bias_reg} > sfc_pkg::BIAS_MAX_US) ? sfc_pkg::BIAS_MAX_US : {1'b0, bias_reg};
		settle_raw = ({settle_reg, 1'b0} > sfc_pkg::SETTLE_MAX_US) ? sfc_pkg::SETTLE_MAX_US : {settle_reg, 1'b0};
		budget_us = sfc_pkg::TOTAL_MAX_US - bias_us - (vcocal ? sfc_pkg::CAL_US : 9'h000);
		settle_us = (settle_raw > budget_us) ? budget_us : settle_raw;
	end

	// Phase timer counts down to zero; a zero-length phase still lasts one cycle
	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			tmr_cnt_reg <= 17'h00000;
		end else if (tmr_load) begin
			tmr_cnt_reg <= (tmr_us == 9'h000) ? 17'h00000 : 17'(int'(tmr_us) * US_CYC - 1);
		end else if (!tmr_done) begin
			tmr_cnt_reg <= tmr_cnt_reg - 17'h00001;
		end
	end
	assign tmr_done = (tmr_cnt_reg == 17'h00000);

	// Turn-on sequencer: bias settle, optional calibration, synth settle, lock
	always_comb begin
		state_next = state_reg;
		tmr_load = 1'b0;
		tmr_us = bias_us;
		latch = 1'b0;
		case (state_reg)
			sfc_pkg::SEQ_OFF: begin
				if (pll_req) begin
					state_next = sfc_pkg::SEQ_BIAS;
					tmr_load = 1'b1;
					latch = 1'b1;
				end
			end
			sfc_pkg::SEQ_BIAS: begin
				if (!pll_req) begin
					state_next = sfc_pkg::SEQ_OFF;
				end else if (tmr_done) begin
					tmr_load = 1'b1;
					if (vcocal) begin
						state_next = sfc_pkg::SEQ_CAL;
						tmr_us = sfc_pkg::CAL_US;
					end else begin
						state_next = sfc_pkg::SEQ_SETTLE;
						tmr_us = settle_us;
					end
				end
			end
			sfc_pkg::SEQ_CAL: begin
				if (!pll_req) begin
					state_next = sfc_pkg::SEQ_OFF;
				end else if (tmr_done) begin
					state_next = sfc_pkg::SEQ_SETTLE;
					tmr_load = 1'b1;
					tmr_us = settle_us;
				end
			end
			sfc_pkg::SEQ_SETTLE: begin
				if (!pll_req) begin
					state_next = sfc_pkg::SEQ_OFF;
				end else if (tmr_done) begin
					state_next = sfc_pkg::SEQ_LOCK;
				end
			end
			sfc_pkg::SEQ_LOCK: begin
				if (!pll_req) begin
					state_next = sfc_pkg::SEQ_OFF;
				end else if (need_retune && !hold_pkt) begin
					state_next = sfc_pkg::SEQ_BIAS;
					tmr_load = 1'b1;
					latch = 1'b1;
				end
			end
			default: state_next = sfc_pkg::SEQ_OFF;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			state_reg <= sfc_pkg::SEQ_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// Frequency and band are taken only at the start of a turn-on sequence
	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			applied_word_reg <= 25'h0000000;
			applied_hb_reg <= 1'b0;
		end else if (latch) begin
			applied_word_reg <= word_want;
			applied_hb_reg <= hb;
		end
	end

	// FSK moves the fraction by the deviation while transmitting
	assign inst_word = pa_en ? (tx_data ? applied_word_reg + dev_w : applied_word_reg - dev_w) : applied_word_reg;

	// Split into integer ratio and fraction below the modulus
	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			synth_reg <= '0;
		end else begin
			synth_reg.n_ratio <= 7'(inst_word / sfc_pkg::FRAC_MOD);
			synth_reg.frac <= 16'(inst_word % sfc_pkg::FRAC_MOD);
		end
	end

	sfc_dsm u_dsm (
		.mclk(mclk),
		.rst_n(rst_sync_n_reg),
		.synth(synth_reg),
		.div_ratio(div_ratio)
	);

	// Outputs decode straight from state flops
	assign pll_en = (state_reg != sfc_pkg::SEQ_OFF);
	assign vco_bias_on = (state_reg == sfc_pkg::SEQ_BIAS);
	assign vco_cal_on = (state_reg == sfc_pkg::SEQ_CAL);
	assign pll_locked = (state_reg == sfc_pkg::SEQ_LOCK);
	assign pa_en = pll_locked & target_tx;
	assign rx_en = pll_locked & target_rx;
	assign hb_select = applied_hb_reg;
	assign lo_div2_en = ~applied_hb_reg;

	// Helper counters read only by the checks below
	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			phase_cnt_reg <= 17'h00000;
			seq_cnt_reg <= 17'h00000;
		end else begin
			phase_cnt_reg <= (state_next != state_reg) ? 17'h00000 : phase_cnt_reg + 17'h00001;
			seq_cnt_reg <= (pll_locked || state_reg == sfc_pkg::SEQ_OFF) ? 17'h00000 : seq_cnt_reg + 17'h00001;
		end
	end

	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (!rst_sync_n_reg);

	band_clamp_a: assert property (wr_stb && wr.addr == sfc_pkg::ADDR_BAND && wr.data[4:0] > 5'h17
		|=> band_reg[4:0] == 5'h17) else $error("band integer not clamped to 23");
	mode_drop_a: assert property (!pll_req |=> state_reg == sfc_pkg::SEQ_OFF ##0 !pa_en && !rx_en)
		else $error("sequencer did not follow target mode");
	cal_entry_a: assert property (vco_bias_on && tmr_done && pll_req && vcocal |=> vco_cal_on)
		else $error("calibration skipped while enabled");
	cal_bypass_a: assert property (vco_bias_on && tmr_done && pll_req && !vcocal
		|=> state_reg == sfc_pkg::SEQ_SETTLE) else $error("bypass did not skip calibration");
	cal_length_a: assert property (vco_cal_on && state_next == sfc_pkg::SEQ_SETTLE
		|-> int'(phase_cnt_reg) + 1 == CAL_CYCLES) else $error("calibration length wrong");
	bias_length_a: assert property (vco_bias_on && tmr_done && pll_req
		|-> int'(phase_cnt_reg) + 1 == ((bias_us == 9'h000) ? 1 : int'(bias_us) * US_CYC))
		else $error("bias settle length wrong");
	settle_length_a: assert property ($rose(pll_locked)
		|-> int'($past(phase_cnt_reg)) + 1 <= int'(sfc_pkg::SETTLE_MAX_US) * US_CYC)
		else $error("synth settle too long");
	total_time_a: assert property (int'(seq_cnt_reg) <= TOTAL_CYCLES + 2)
		else $error("turn-on exceeded 200 us");
	retune_a: assert property (pll_locked && pll_req && need_retune && !hold_pkt
		|=> vco_bias_on && !pa_en && !rx_en ##1 $stable(applied_word_reg))
		else $error("frequency change did not retune");
	pkt_hold_a: assert property (pll_locked && pll_req && hold_pkt |=> pll_locked)
		else $error("retune broke a packet");
	word_hold_a: assert property (state_reg inside {sfc_pkg::SEQ_CAL, sfc_pkg::SEQ_SETTLE}
		|=> $stable(applied_word_reg) && $stable(applied_hb_reg)) else $error("word changed mid-sequence");
	rx_shift_a: assert property (rx_en && !need_retune |-> applied_word_reg + if_w == word_nom)
		else $error("receive IF shift missing");
	frac_split_a: assert property (synth_reg.frac < 16'hfa00
		&& {18'h00000, synth_reg.n_ratio} * sfc_pkg::FRAC_MOD + {9'h000, synth_reg.frac} == $past(inst_word))
		else $error("ratio split wrong");
endmodule : sfc_synth_ctrl

/* rtl/sfc_pkg.sv */
package sfc_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PS_PER_US = 1000000;
	localparam int US_CYCLES = (PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REF_PERIOD_PS = 100000;
	localparam int REF_DIV = REF_PERIOD_PS / CLK_PERIOD_PS;

	// Sequencer intervals, in microseconds
	localparam logic [8:0] BIAS_MAX_US = 9'h046;
	localparam logic [8:0] CAL_US = 9'h032;
	localparam logic [8:0] SETTLE_MAX_US = 9'h136;
	localparam logic [8:0] TOTAL_MAX_US = 9'h0c8;

	// Register addresses
	localparam logic [6:0] ADDR_DEV_STATUS = 7'h02;
	localparam logic [6:0] ADDR_OP_MODE = 7'h07;
	localparam logic [6:0] ADDR_DEVIATION = 7'h72;
	localparam logic [6:0] ADDR_OFFSET_LO = 7'h73;
	localparam logic [6:0] ADDR_OFFSET_HI = 7'h74;
	localparam logic [6:0] ADDR_BAND = 7'h75;
	localparam logic [6:0] ADDR_FRAC_HI = 7'h76;
	localparam logic [6:0] ADDR_FRAC_LO = 7'h77;
	localparam logic [6:0] ADDR_CHANNEL = 7'h79;
	localparam logic [6:0] ADDR_STEP = 7'h7a;
	localparam logic [6:0] ADDR_SEQ_CFG = 7'h7b;
	localparam logic [6:0] ADDR_BIAS_TIME = 7'h7c;
	localparam logic [6:0] ADDR_SETTLE_TIME = 7'h7d;

	// Values after reset
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DEVIATION = 8'h20;
	localparam logic [7:0] RST_BAND = 8'h35;
	localparam logic [7:0] RST_FRAC_HI = 8'hbb;
	localparam logic [7:0] RST_FRAC_LO = 8'h80;
	localparam logic [7:0] RST_SEQ_CFG = 8'h01;
	localparam logic [7:0] RST_BIAS_TIME = 8'h32;
	localparam logic [7:0] RST_SETTLE_TIME = 8'h32;

	// Field positions
	localparam int OPM_PLLON = 1;
	localparam int OPM_RXON = 2;
	localparam int OPM_TXON = 3;
	localparam int BAND_HB = 5;
	localparam int CFG_VCOCAL = 0;
	localparam int CFG_LOCKED = 7;

	// Frequency plan, in millihertz; one fraction step is 156.25 Hz in low band
	localparam int LSB_MHZ = 156250;
	localparam int IF_SHIFT_MHZ = 937500000;
	localparam int HOP_UNIT_MHZ = 10000000;
	localparam int DEV_UNIT_MHZ = 625000;
	localparam logic [24:0] IF_LSB = 25'(IF_SHIFT_MHZ / LSB_MHZ);
	localparam logic [24:0] HOP_LSB = 25'(HOP_UNIT_MHZ / LSB_MHZ);
	localparam logic [24:0] DEV_LSB = 25'(DEV_UNIT_MHZ / LSB_MHZ);
	localparam logic [24:0] FRAC_MOD = 25'h00fa00;
	localparam logic [15:0] FRAC_MOD16 = 16'hfa00;
	localparam logic [6:0] N_OFFSET = 7'h18;
	localparam logic [4:0] FB_MAX = 5'h17;

	typedef enum logic [4:0] {
		SEQ_OFF = 5'h01,
		SEQ_BIAS = 5'h02,
		SEQ_CAL = 5'h04,
		SEQ_SETTLE = 5'h08,
		SEQ_LOCK = 5'h10
	} sfc_seq_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} sfc_reg_wr_t;

	typedef struct packed {
		logic [6:0] n_ratio;
		logic [15:0] frac;
	} sfc_synth_t;
endpackage : sfc_pkg

/* rtl/sfc_spi_port.sv */
`timescale 1ns/1ps
module sfc_spi_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_nsel_n,
	input wire logic spi_sdi,
	input wire logic [7:0] rd_data,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	output logic wr_stb,
	output sfc_pkg::sfc_reg_wr_t wr,
	output logic [6:0] rd_addr
);
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic sck_d_reg;
	logic rise;
	logic fall;
	logic [2:0] bit_cnt_reg;
	logic [6:0] rx_sh_reg;
	logic addr_ph_reg;
	logic is_wr_reg;
	logic [6:0] addr_reg;
	logic load_reg;
	logic [7:0] tx_sh_reg;

	// Pins pass two flops; the first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 3'h2;
			sync_reg <= 3'h2;
			sck_d_reg <= 1'b0;
		end else begin
			meta_reg <= {spi_sck, spi_nsel_n, spi_sdi};
			sync_reg <= meta_reg;
			sck_d_reg <= sync_reg[2];
		end
	end

	assign rise = sync_reg[2] & ~sck_d_reg;
	assign fall = ~sync_reg[2] & sck_d_reg;

	// Receive: first byte is write flag and address, then data bytes with auto increment
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_reg <= 3'h0;
			rx_sh_reg <= 7'h00;
			addr_ph_reg <= 1'b1;
			is_wr_reg <= 1'b0;
			addr_reg <= 7'h00;
			wr_stb <= 1'b0;
			wr <= '0;
		end else begin
			wr_stb <= 1'b0;
			if (sync_reg[1]) begin
				bit_cnt_reg <= 3'h0;
				addr_ph_reg <= 1'b1;
			end else if (rise) begin
				rx_sh_reg <= {rx_sh_reg[5:0], sync_reg[0]};
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7) begin
					if (addr_ph_reg) begin
						is_wr_reg <= rx_sh_reg[6];
						addr_reg <= {rx_sh_reg[5:0], sync_reg[0]};
						addr_ph_reg <= 1'b0;
					end else begin
						addr_reg <= addr_reg + 7'h01;
						if (is_wr_reg) begin
							wr_stb <= 1'b1;
							wr.addr <= addr_reg;
							wr.data <= {rx_sh_reg, sync_reg[0]};
						end
					end
				end
			end
		end
	end

	// Transmit: read data is loaded on the falling edge after each completed byte of a read frame
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			load_reg <= 1'b0;
			tx_sh_reg <= 8'h00;
			spi_sdo_oe <= 1'b0;
		end else begin
			spi_sdo_oe <= ~sync_reg[1];
			if (sync_reg[1]) begin
				load_reg <= 1'b0;
				tx_sh_reg <= 8'h00;
			end else if (rise && bit_cnt_reg == 3'h7) begin
				load_reg <= addr_ph_reg ? ~rx_sh_reg[6] : ~is_wr_reg;
			end else if (fall) begin
				load_reg <= 1'b0;
				tx_sh_reg <= load_reg ? rd_data : {tx_sh_reg[6:0], 1'b0};
			end
		end
	end

	assign spi_sdo = tx_sh_reg[7];
	assign rd_addr = addr_reg;
endmodule : sfc_spi_port

/* rtl/sfc_dsm.sv */
`timescale 1ns/1ps
module sfc_dsm (
	input wire logic mclk,
	input wire logic rst_n,
	input wire sfc_pkg::sfc_synth_t synth,
	output logic [7:0] div_ratio
);
	logic [4:0] ref_cnt_reg;
	logic ref_tick;
	logic [2:0][15:0] acc_reg;
	logic [2:0][15:0] acc_next;
	logic [2:0][15:0] stage_in;
	logic [2:0] carry;
	logic c2_d_reg;
	logic c3_d_reg;
	logic c3_dd_reg;
	logic [3:0] delta;

	// Modulator runs at the 10 MHz reference rate
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_reg <= 5'h00;
		end else begin
			ref_cnt_reg <= ref_tick ? 5'h00 : ref_cnt_reg + 5'h01;
		end
	end
	assign ref_tick = (ref_cnt_reg == 5'(sfc_pkg::REF_DIV - 1));

	// Three cascaded accumulators, each wrapping at the fraction modulus
	assign stage_in[0] = synth.frac;
	for (genvar k = 0; k < 3; k++) begin : g_stage
		logic [16:0] sum;
		assign sum = {1'b0, acc_reg[k]} + {1'b0, stage_in[k]};
		assign carry[k] = (sum >= {1'b0, sfc_pkg::FRAC_MOD16});
		assign acc_next[k] = carry[k] ? 16'(sum - {1'b0, sfc_pkg::FRAC_MOD16}) : sum[15:0];
		if (k < 2) begin : g_chain
			assign stage_in[k + 1] = acc_next[k];
		end
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				acc_reg[k] <= 16'h0000;
			end else if (ref_tick) begin
				acc_reg[k] <= acc_next[k];
			end
		end
	end

	// Noise-shaped carry sum: c1 + (1-z)c2 + (1-z)^2 c3
	assign delta = {3'h0, carry[0]} + {3'h0, carry[1]} - {3'h0, c2_d_reg}
		+ {3'h0, carry[2]} - {2'h0, c3_d_reg, 1'b0} + {3'h0, c3_dd_reg};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c2_d_reg <= 1'b0;
			c3_d_reg <= 1'b0;
			c3_dd_reg <= 1'b0;
			div_ratio <= 8'h00;
		end else if (ref_tick) begin
			c2_d_reg <= carry[1];
			c3_d_reg <= carry[2];
			c3_dd_reg <= c3_d_reg;
			div_ratio <= {1'b0, synth.n_ratio} + {{4{delta[3]}}, delta};
		end
	end
endmodule : sfc_dsm

/* tb/sfc_host_model.sv */
`timescale 1ns/1ps
// Host side of the serial port: mode 0 master, sck rests low between frames
module sfc_host_model (
	input wire logic mclk,
	output logic spi_sck,
	output logic spi_nsel_n,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	// Half period of sck in mclk cycles; the port needs at least 4 for its synchronisers
	localparam int HALF = 6;
	initial begin
		spi_sck = 1'b0;
		spi_nsel_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// One frame of 16 bits, MSB first; read bits are taken just before each rising sck
	task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
		logic [15:0] sh;
		sh = {wr, addr, wdata};
		@(posedge mclk) spi_nsel_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge mclk) spi_sdi <= sh[i];
			repeat (HALF) @(posedge mclk);
			if (i < 8) rdata[i] = spi_sdo;
			spi_sck <= 1'b1;
			repeat (HALF) @(posedge mclk);
			spi_sck <= 1'b0;
		end
		repeat (HALF) @(posedge mclk);
		spi_nsel_n <= 1'b1;
		// Released data line must not look like a held value
		spi_sdi <= ~spi_sdi;
		repeat (6) @(posedge mclk);
	endtask : xfer
endmodule : sfc_host_model

/* tb/synth_frequency_control_bench.sv */
`timescale 1ns/1ps
module synth_frequency_control_bench;
	localparam int US = 2;
	logic mclk, rst_n, tx_data, pkt_active, spi_sck, spi_nsel_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic pll_en, vco_bias_on, vco_cal_on, pll_locked, pa_en, rx_en, hb_select, lo_div2_en;
	logic [7:0] div_ratio, rd, d;
	logic [31:0] seed = 32'h42bf;
	int n_mismatch = 0, checked = 0, nb = 0, nc = 0, nr = 0;
	// Model of the programmed frequency word
	int fb = 21, hb = 1, fc = 48000, fo = 0, ch = 0, stp = 0, rx = 0;
	logic [6:0] ra [6] = '{7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h10};
	logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h35, 8'hbb, 8'h80, 8'h00};

	sfc_synth_ctrl #(.US_CYC(US)) dut (.mclk, .rst_n, .spi_sck, .spi_nsel_n, .spi_sdi, .spi_sdo, .spi_sdo_oe,
		.tx_data, .pkt_active, .pll_en, .vco_bias_on, .vco_cal_on, .pll_locked, .pa_en, .rx_en, .hb_select,
		.lo_div2_en, .div_ratio);
	sfc_host_model host (.mclk, .spi_sck, .spi_nsel_n, .spi_sdi, .spi_sdo);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Phase lengths; zeroed by the sequence before each run
	always @(posedge mclk) begin
		nb += vco_bias_on;
		nc += vco_cal_on;
		nr += (pll_en & ~pll_locked);
	end
	// Random FSK data every cycle, from the shared generator
	always @(posedge mclk) begin
		seed = xs(seed);
		tx_data <= seed[0];
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		host.xfer(1'b1, a, v, rd);
	endtask : wr
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		host.xfer(1'b0, a, 8'h00, rd);
		chk("register", e, rd);
	endtask : rdchk
	// Bounded wait for a finished turn-on sequence, sampled away from the clock edge
	task automatic waitlock();
		int i;
		for (i = 0; i < 5000; i++) begin
			@(negedge mclk);
			if (pll_locked === 1'b1 && nr > 0) break;
		end
		if (i == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : waitlock
	task automatic tune(input logic [6:0] a, input logic [7:0] v);
		nb = 0;
		nc = 0;
		nr = 0;
		wr(a, v);
		waitlock();
	endtask : tune
	// Mean divide ratio over 800 reference ticks against the word, within the modulator's spread
	task automatic avg(input string what);
		longint w, s;
		w = (fb + 24) * 64000 + fc + fo + ((ch * stp * 64) >> hb) - (rx ? (6000 >> hb) : 0);
		s = 0;
		for (int k = 0; k < 800; k++) begin
			repeat (20) @(posedge mclk);
			s += div_ratio;
		end
		chk(what, 1, (s * 64000 - 800 * w <= 256000) && (800 * w - s * 64000 <= 256000));
	endtask : avg

	initial begin
		rst_n = 1'b0;
		pkt_active = 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("lo_div2_en", 1, lo_div2_en);
		chk("spi_sdo_oe", 0, spi_sdo_oe);
		foreach (ra[i]) rdchk(ra[i], rv[i]);
		// Band integer above the top value is stored as the top value
		for (int i = 0; i < 4; i++) begin
			d = i ? {3'b001, seed[4:0]} : 8'h3f;
			wr(7'h75, d);
			rdchk(7'h75, {3'b001, (d[4:0] > 5'd23) ? 5'd23 : d[4:0]});
		end
		wr(7'h75, 8'h35);
		// Upper offset bits are narrow; this value makes the offset negative
		wr(7'h74, 8'hfe);
		rdchk(7'h74, 8'h02);
		fo = -512;
		stp = seed[7:0] | 1;
		wr(7'h7a, stp[7:0]);
		// Transmit from off with default intervals
		tune(7'h07, 8'h08);
		chk("bias", 50 * US, nb);
		chk("cal", 50 * US, nc);
		chk("total", 1, nr <= 200 * US + 2);
		chk("outputs", 4'b1010, {pa_en, rx_en, hb_select, lo_div2_en});
		avg("tx word");
		// Longest bias, calibration bypassed, then a channel change
		wr(7'h7c, 8'hff);
		wr(7'h7b, 8'h00);
		ch = seed[15:8] | 1;
		tune(7'h79, ch[7:0]);
		chk("bias max", 70 * US, nb);
		chk("cal skipped", 0, nc);
		chk("total", 1, nr <= 200 * US + 2);
		avg("hop word");
		// A hop during a packet waits for the packet to end
		pkt_active <= 1'b1;
		ch = (ch + 1) % 256;
		nr = 0;
		wr(7'h79, ch[7:0]);
		repeat (100) @(posedge mclk);
		chk("held", 1, pll_locked === 1'b1 && pa_en === 1'b1 && nr == 0);
		pkt_active <= 1'b0;
		waitlock();
		avg("hop word");
		// Receive on the same channel without touching frequency registers
		rx = 1;
		tune(7'h07, 8'h04);
		chk("rx outputs", 2'b01, {pa_en, rx_en});
		avg("rx word");
		rdchk(7'h02, 8'h01);
		// Tune-only target drops the IF shift, so it retunes and stays locked with no path on
		tune(7'h07, 8'h02);
		chk("tune outputs", 3'h4, {pll_locked, pa_en, rx_en});
		rdchk(7'h7b, 8'h80);
		wr(7'h07, 8'h00);
		repeat (4) @(posedge mclk);
		chk("off", 0, pll_en);
		print_verdict();
	end
endmodule : synth_frequency_control_bench
